// File: ecc_pkg.sv
// Constants shared by the page code engine and its accumulator
package ecc_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_CR = 8'h00;
  localparam logic [7:0] OFF_MR = 8'h04;
  localparam logic [7:0] OFF_SR1 = 8'h08;
  localparam logic [7:0] OFF_PR0 = 8'h0C;
  localparam logic [7:0] OFF_PR1 = 8'h10;
  localparam logic [7:0] OFF_SR2 = 8'h14;
  localparam logic [7:0] OFF_PR2 = 8'h18;
  localparam logic [7:0] OFF_PR15 = 8'h4C;
  localparam int NUM_PR = 16;
  // Control register bits
  localparam int CR_RST_BIT = 0;
  localparam int CR_SRST_BIT = 1;
  // Mode register fields
  localparam int MR_PAGE_LSB = 0;
  localparam int MR_TYPE_LSB = 4;
  localparam int MR_WIDE_BIT = 8;
  localparam logic [31:0] MR_RESET = 32'h0000_0000;
  localparam logic [31:0] MR_MASK = 32'h0000_0133;
  localparam logic [31:0] REG_RESET = 32'h0000_0000;
  // Page size encodings and main-area word counts
  localparam logic [1:0] PG_528 = 2'h0;
  localparam logic [1:0] PG_2112 = 2'h1;
  localparam logic [12:0] MAIN_528 = 13'h0200;
  localparam logic [12:0] MAIN_2112 = 13'h0800;
  localparam logic [12:0] MAIN_4224 = 13'h1000;
  // Correction type encodings and sector byte counts
  localparam logic [1:0] TYPE_PAGE = 2'h0;
  localparam logic [1:0] TYPE_512 = 2'h1;
  localparam logic [12:0] SEC_BYTES_512 = 13'h0200;
  localparam logic [12:0] SEC_BYTES_256 = 13'h0100;
  // NAND commands that open a protected page
  localparam logic [7:0] CMD_READ = 8'h00;
  localparam logic [7:0] CMD_PROG = 8'h80;
  // Code word layout
  localparam int CODE_COL_LSB = 0;
  localparam int CODE_ROW_LSB = 8;
  localparam int CODE_ROWN_LSB = 20;
  localparam int IDX_W = 12;
  localparam logic [7:0] COL_MASK_8 = 8'h3F;
  localparam logic [7:0] COL_MASK_16 = 8'hFF;
  // Status nibble per sector
  localparam int FLAG_REC = 0;
  localparam int FLAG_CODE = 1;
  localparam int FLAG_MUL = 2;
  localparam int SECTORS_PER_SR = 8;
endpackage : ecc_pkg

// File: parity_if.sv
// Link between the engine and its parity accumulator
`timescale 1ns/1ps
interface parity_if;
  logic clr;
  logic valid;
  logic wide;
  logic [15:0] data;
  logic [11:0] idx;
  logic [31:0] code_next;
  modport engine(output clr, output valid, output wide, output data, output idx,
                 input code_next);
  modport acc(input clr, input valid, input wide, input data, input idx,
              output code_next);
endinterface : parity_if

// File: parity_acc.sv
// Row and column parity accumulator for one sector
`timescale 1ns/1ps
module parity_acc
  import ecc_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  parity_if.acc p
);
  logic [31:0] acc_q;
  logic [31:0] acc_d;
  logic [31:0] contrib;
  logic [15:0] d;
  logic wp;

  // Bits whose position has bit k set
  function automatic logic [15:0] sel_mask(input int k);
    case (k)
      0: sel_mask = 16'hAAAA;
      1: sel_mask = 16'hCCCC;
      2: sel_mask = 16'hF0F0;
      default: sel_mask = 16'hFF00;
    endcase
  endfunction : sel_mask

  always_comb begin
    d = p.wide ? p.data : {8'h00, p.data[7:0]};
    wp = ^d;
    contrib = '0;
    for (int i = 0; i < IDX_W; i++) begin
      contrib[CODE_ROW_LSB + i] = wp & p.idx[i];
      contrib[CODE_ROWN_LSB + i] = wp & ~p.idx[i];
    end
    for (int k = 0; k < 4; k++) begin
      contrib[CODE_COL_LSB + 2 * k] = ^(d & sel_mask(k));
      contrib[CODE_COL_LSB + 2 * k + 1] = ^(d & ~sel_mask(k));
    end
    p.code_next = acc_q ^ (p.valid ? contrib : 32'h0000_0000);
    acc_d = p.clr ? 32'h0000_0000 : p.code_next;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      acc_q <= 32'h0000_0000;
    end else begin
      acc_q <= acc_d;
    end
  end
endmodule : parity_acc

// File: nand_page_ecc_engine.sv
// NAND page code engine with its register slave
`timescale 1ns/1ps
module nand_page_ecc_engine
  import ecc_pkg::*;
(
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  input wire logic NAND_CMD_STB,
  input wire logic NAND_ADDR_STB,
  input wire logic NAND_DATA_STB,
  input wire logic [15:0] NAND_DATA
);
  typedef enum logic [1:0] {ST_IDLE, ST_ADDR, ST_MAIN, ST_SPARE} state_t;

  state_t state_q, state_d;
  logic read_q, read_d;
  logic addr_seen_q, addr_seen_d;
  logic [12:0] cnt_q, cnt_d;
  logic [4:0] sec_q, sec_d;
  logic [4:0] sp_sec_q, sp_sec_d;
  logic [1:0] sp_part_q, sp_part_d;
  logic [31:0] stored_q, stored_d;
  logic [31:0] pr_q [NUM_PR];
  logic [31:0] pr_d [NUM_PR];
  logic [31:0] sr1_q, sr1_d, sr2_q, sr2_d;
  logic [31:0] mode_q, mode_d;
  logic [31:0] prdata_q, prdata_d;

  logic wide;
  logic [12:0] main_words, sec_words;
  logic [11:0] row_mask;
  logic [7:0] col_mask;
  logic [31:0] code_mask, syn;
  logic [2:0] flags;
  logic word_in, sec_end, last_part, clear_all;
  logic [3:0] pr_idx;

  parity_if pif ();

  parity_acc u_acc (
    .clk(CLK),
    .rstn(RSTN),
    .p(pif.acc)
  );

  // Classify a syndrome into recoverable, stored-code or multiple error
  function automatic logic [2:0] classify(input logic [31:0] s, input logic [11:0] rm,
                                          input logic w);
    logic pairs_ok;
    logic [3:0] cp;
    logic [3:0] cm;
    cp = {s[6] ^ s[7], s[4] ^ s[5], s[2] ^ s[3], s[0] ^ s[1]};
    cm = w ? 4'hF : 4'h7;
    pairs_ok = ((s[19:8] ^ s[31:20]) == rm) && (cp == cm);
    classify = 3'h0;
    if (s != 32'h0000_0000) begin
      if (pairs_ok) begin
        classify[FLAG_REC] = 1'b1;
      end else if ((s & (s - 32'h0000_0001)) == 32'h0000_0000) begin
        classify[FLAG_CODE] = 1'b1;
      end else begin
        classify[FLAG_MUL] = 1'b1;
      end
    end
  endfunction : classify

  // Geometry from the mode register
  always_comb begin
    wide = mode_q[MR_WIDE_BIT];
    case (mode_q[MR_PAGE_LSB +: 2])
      PG_528: main_words = MAIN_528;
      PG_2112: main_words = MAIN_2112;
      default: main_words = MAIN_4224;
    endcase
    case (mode_q[MR_TYPE_LSB +: 2])
      TYPE_PAGE: sec_words = main_words;
      TYPE_512: sec_words = wide ? SEC_BYTES_512 >> 1 : SEC_BYTES_512;
      default: sec_words = wide ? SEC_BYTES_256 >> 1 : SEC_BYTES_256;
    endcase
    row_mask = 12'(sec_words - 13'h0001);
    col_mask = wide ? COL_MASK_16 : COL_MASK_8;
    code_mask = {row_mask, row_mask, col_mask};
  end

  always_comb begin
    state_d = state_q;
    read_d = read_q;
    addr_seen_d = addr_seen_q;
    cnt_d = cnt_q;
    sec_d = sec_q;
    sp_sec_d = sp_sec_q;
    sp_part_d = sp_part_q;
    stored_d = stored_q;
    pr_d = pr_q;
    sr1_d = sr1_q;
    sr2_d = sr2_q;
    mode_d = mode_q;
    prdata_d = prdata_q;
    pif.clr = 1'b0;
    pif.valid = 1'b0;
    pif.wide = wide;
    pif.data = NAND_DATA;
    pif.idx = cnt_q[11:0] & row_mask;
    syn = 32'h0000_0000;
    flags = 3'h0;
    last_part = 1'b0;
    pr_idx = 4'h0;
    clear_all = 1'b0;

    // Register slave, read data captured in the setup phase
    if (PSEL && !PENABLE && !PWRITE) begin
      if (PADDR == OFF_MR) begin
        prdata_d = mode_q;
      end else if (PADDR == OFF_SR1) begin
        prdata_d = sr1_q;
      end else if (PADDR == OFF_SR2) begin
        prdata_d = sr2_q;
      end else if (PADDR == OFF_PR0) begin
        prdata_d = pr_q[0];
      end else if (PADDR == OFF_PR1) begin
        prdata_d = pr_q[1];
      end else if (PADDR >= OFF_PR2 && PADDR <= OFF_PR15 && PADDR[1:0] == 2'h0) begin
        pr_idx = 4'((PADDR - OFF_PR2) >> 2) + 4'h2;
        prdata_d = pr_q[pr_idx];
      end else begin
        prdata_d = REG_RESET;
      end
    end
    if (PSEL && PENABLE && PWRITE) begin
      if (PADDR == OFF_MR) begin
        mode_d = PWDATA & MR_MASK;
      end else if (PADDR == OFF_CR) begin
        clear_all = PWDATA[CR_RST_BIT] | PWDATA[CR_SRST_BIT];
        if (PWDATA[CR_SRST_BIT]) begin
          state_d = ST_IDLE;
        end
      end
    end

    // Start command
    if (NAND_CMD_STB && (NAND_DATA[7:0] == CMD_READ || NAND_DATA[7:0] == CMD_PROG)) begin
      state_d = ST_ADDR;
      read_d = (NAND_DATA[7:0] == CMD_READ);
      addr_seen_d = 1'b0;
      cnt_d = 13'h0000;
      sec_d = 5'h00;
      sp_sec_d = 5'h00;
      sp_part_d = 2'h0;
      pif.clr = 1'b1;
      clear_all = 1'b1;
    end
    if (clear_all) begin
      sr1_d = REG_RESET;
      sr2_d = REG_RESET;
      for (int i = 0; i < NUM_PR; i++) begin
        pr_d[i] = REG_RESET;
      end
    end

    case (state_q)
      ST_IDLE: begin
      end
      ST_ADDR: begin
        if (NAND_ADDR_STB) begin
          addr_seen_d = 1'b1;
        end
      end
      ST_MAIN: begin
      end
      ST_SPARE: begin
        if (NAND_DATA_STB && !NAND_CMD_STB) begin
          stored_d = wide ? {NAND_DATA, stored_q[31:16]} : {NAND_DATA[7:0], stored_q[31:8]};
          last_part = wide ? sp_part_q[0] : (sp_part_q == 2'h3);
          sp_part_d = last_part ? 2'h0 : sp_part_q + 2'h1;
          if (last_part) begin
            syn = (stored_d ^ pr_q[sp_sec_q[3:0]]) & code_mask;
            flags = classify(syn, row_mask, wide);
            if (sp_sec_q < 5'(SECTORS_PER_SR)) begin
              sr1_d[{sp_sec_q[2:0], 2'h0} +: 3] = flags;
            end else begin
              sr2_d[{sp_sec_q[2:0], 2'h0} +: 3] = flags;
            end
            if (flags[FLAG_REC]) begin
              pr_d[sp_sec_q[3:0]] = {16'h0000,
                12'(sp_sec_q * sec_words) + syn[19:8],
                syn[6], syn[4], syn[2], syn[0]};
            end
            sp_sec_d = sp_sec_q + 5'h01;
            if (sp_sec_d == sec_q) begin
              state_d = ST_IDLE;
            end
          end
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase

    // Main-area word: accumulate, lock at sector and page ends
    word_in = NAND_DATA_STB && !NAND_CMD_STB &&
              (state_q == ST_MAIN || (state_q == ST_ADDR && addr_seen_q));
    sec_end = (pif.idx == row_mask);
    if (word_in) begin
      pif.valid = 1'b1;
      cnt_d = cnt_q + 13'h0001;
      state_d = ST_MAIN;
      if (sec_end) begin
        pr_d[sec_q[3:0]] = pif.code_next & code_mask;
        pif.clr = 1'b1;
        sec_d = sec_q + 5'h01;
      end
      if (cnt_q == main_words - 13'h0001) begin
        state_d = read_q ? ST_SPARE : ST_IDLE;
      end
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      state_q <= ST_IDLE;
      read_q <= 1'b0;
      addr_seen_q <= 1'b0;
      cnt_q <= 13'h0000;
      sec_q <= 5'h00;
      sp_sec_q <= 5'h00;
      sp_part_q <= 2'h0;
      stored_q <= 32'h0000_0000;
      for (int i = 0; i < NUM_PR; i++) begin
        pr_q[i] <= REG_RESET;
      end
      sr1_q <= REG_RESET;
      sr2_q <= REG_RESET;
      mode_q <= MR_RESET;
      prdata_q <= REG_RESET;
    end else begin
      state_q <= state_d;
      read_q <= read_d;
      addr_seen_q <= addr_seen_d;
      cnt_q <= cnt_d;
      sec_q <= sec_d;
      sp_sec_q <= sp_sec_d;
      sp_part_q <= sp_part_d;
      stored_q <= stored_d;
      pr_q <= pr_d;
      sr1_q <= sr1_d;
      sr2_q <= sr2_d;
      mode_q <= mode_d;
      prdata_q <= prdata_d;
    end
  end

  assign PRDATA = prdata_q;
endmodule : nand_page_ecc_engine

// File: nand_page_ecc_engine_sva.sv
// Checker for the page code engine register port
`timescale 1ns/1ps
module nand_page_ecc_engine_sva
  import ecc_pkg::*;
(
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic NAND_CMD_STB,
  input wire logic NAND_ADDR_STB,
  input wire logic NAND_DATA_STB,
  input wire logic [15:0] NAND_DATA
);
  logic rd, res, wr, st, clr;
  logic [31:0] mr_q, mr_d, val_q, val_d;
  logic [7:0] adr_q, adr_d;
  logic cln_q, cln_d, qt_q, qt_d, pg_q, pg_d;
  assign rd = PSEL && !PENABLE && !PWRITE;
  assign res = rd && PADDR >= OFF_SR1 && PADDR <= OFF_PR15 && PADDR[1:0] == 2'h0;
  assign wr = PSEL && PENABLE && PWRITE;
  assign st = NAND_CMD_STB && (NAND_DATA[7:0] == CMD_READ || NAND_DATA[7:0] == CMD_PROG);
  assign clr = wr && PADDR == OFF_CR && PWDATA[1:0] != 2'h0;
  always_comb begin
    mr_d = (wr && PADDR == OFF_MR) ? (PWDATA & MR_MASK) : mr_q;
    adr_d = rd ? PADDR : adr_q;
    val_d = (PSEL && PENABLE && !PWRITE) ? PRDATA : val_q;
    qt_d = (rd || qt_q) && !(st || clr || NAND_DATA_STB);
    cln_d = (cln_q || st || clr) && !NAND_DATA_STB;
    pg_d = st ? (mr_q[MR_TYPE_LSB +: 2] == TYPE_PAGE) : pg_q;
  end
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      mr_q <= MR_RESET;
      val_q <= 32'h0;
      adr_q <= 8'hFF;
      qt_q <= 1'b0;
      cln_q <= 1'b1;
      pg_q <= 1'b1;
    end else begin
      mr_q <= mr_d;
      val_q <= val_d;
      adr_q <= adr_d;
      qt_q <= qt_d;
      cln_q <= cln_d;
      pg_q <= pg_d;
    end
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (!RSTN);
  property p_rd_only;
    $changed(PRDATA) |-> $past(rd);
  endproperty
  a_rd_only: assert property (p_rd_only) else $error("read data moved");
  property p_unmapped;
    rd && (PADDR > OFF_PR15 || PADDR[1:0] != 2'h0) |=> PRDATA == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped not zero");
  property p_mode;
    rd && PADDR == OFF_MR |=> PRDATA == mr_q;
  endproperty
  a_mode: assert property (p_mode) else $error("mode readback");
  property p_clear;
    cln_q && res |=> PRDATA == 32'h0;
  endproperty
  a_clear: assert property (p_clear) else $error("result not cleared");
  property p_frozen;
    qt_q && res && PADDR == adr_q |=> PRDATA == val_q;
  endproperty
  a_frozen: assert property (p_frozen) else $error("result moved");
  property p_one_code;
    pg_q && res && PADDR != OFF_SR1 && PADDR != OFF_PR0 |=> PRDATA == 32'h0;
  endproperty
  a_one_code: assert property (p_one_code) else $error("extra code");
  property p_one_flag;
    pg_q && rd && PADDR == OFF_SR1 |=> PRDATA[31:4] == 28'h0;
  endproperty
  a_one_flag: assert property (p_one_flag) else $error("extra flags");
  property p_flag_rsv;
    rd && (PADDR == OFF_SR1 || PADDR == OFF_SR2) |=> (PRDATA & 32'h8888_8888) == 32'h0;
  endproperty
  a_flag_rsv: assert property (p_flag_rsv) else $error("flag spare bit");
endmodule : nand_page_ecc_engine_sva
bind nand_page_ecc_engine nand_page_ecc_engine_sva i_nand_page_ecc_engine_sva(.CLK(CLK),
  .RSTN(RSTN), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
  .PWDATA(PWDATA), .PRDATA(PRDATA), .NAND_CMD_STB(NAND_CMD_STB),
  .NAND_ADDR_STB(NAND_ADDR_STB), .NAND_DATA_STB(NAND_DATA_STB), .NAND_DATA(NAND_DATA));

// File: nand_bus_model.sv
// Flash bus side model driving command, address and data strobes
`timescale 1ns/1ps
module nand_bus_model (
  output logic cmd_stb,
  output logic addr_stb,
  output logic data_stb,
  output logic [15:0] data,
  input wire logic clk
);
  initial begin
    {cmd_stb, addr_stb, data_stb} = 3'h0;
    data = 16'h0;
  end
  task automatic pulse(input logic [2:0] k, input logic [15:0] v);
    @(negedge clk);
    {cmd_stb, addr_stb, data_stb} = k;
    data = v;
    @(negedge clk);
    {cmd_stb, addr_stb, data_stb} = 3'h0;
    data = ~v; // Idle bus shows no stale word
  endtask : pulse
  // Words at multiples of stride carry w0, then n stored code units
  task automatic page(input logic [7:0] cmd, input logic [15:0] w0, input int stride,
                      input int words, input int n, input logic [31:0] code, input bit wide);
    pulse(3'h4, {8'h00, cmd});
    pulse(3'h2, 16'h0000);
    pulse(3'h2, 16'h0000);
    for (int i = 0; i < words; i++) begin
      pulse(3'h1, (i % stride == 0) ? w0 : 16'h0000);
    end
    for (int i = 0; i < n; i++) begin
      pulse(3'h1, wide ? code[16*i +: 16] : {8'h00, code[8*i +: 8]});
    end
  endtask : page
endmodule : nand_bus_model

// File: nand_page_ecc_engine_tb_top.sv
// Self-checking bench for the page code engine
`timescale 1ns/1ps
module nand_page_ecc_engine_tb_top
  import ecc_pkg::*;
();
  logic CLK, RSTN, PSEL, PENABLE, PWRITE, cs, as, ds;
  logic [7:0] PADDR;
  logic [31:0] PWDATA, PRDATA, rd_v;
  logic [15:0] nd;
  logic [15:0] w[4] = '{16'h0001, 16'h0003, 16'h0001, 16'h0007};
  logic [31:0] cd[4] = '{32'h1FF0_002A, 32'h1FF0_002A, 32'h1FF0_002B, 32'h1FF0_002A};
  logic [31:0] sr[4] = '{32'h0, 32'h1, 32'h2, 32'h4};
  int err_count, samples_checked;
  nand_page_ecc_engine i_nand_page_ecc_engine(.CLK(CLK), .RSTN(RSTN), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .NAND_CMD_STB(cs), .NAND_ADDR_STB(as), .NAND_DATA_STB(ds), .NAND_DATA(nd));
  nand_bus_model i_nand_bus_model(.cmd_stb(cs), .addr_stb(as), .data_stb(ds), .data(nd),
    .clk(CLK));
  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end
  task automatic report_and_stop();
    if (err_count == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : report_and_stop
  task automatic apb_wr(input logic [7:0] a, input logic [31:0] d);
    @(negedge CLK);
    {PSEL, PWRITE, PADDR, PWDATA} = {2'b11, a, d};
    @(negedge CLK);
    PENABLE = 1'b1;
    @(negedge CLK);
    {PSEL, PENABLE} = 2'b00;
  endtask : apb_wr
  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
    @(negedge CLK);
    {PSEL, PWRITE, PADDR} = {2'b10, a};
    @(negedge CLK);
    PENABLE = 1'b1;
    @(posedge CLK);
    rd_v = PRDATA;
    @(negedge CLK);
    {PSEL, PENABLE} = 2'b00;
    samples_checked++;
    if (rd_v !== e) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", nm, e, rd_v);
    end
  endtask : rd_chk
  initial begin
    repeat (100000) @(posedge CLK);
    err_count++;
    report_and_stop();
  end
  initial begin
    {RSTN, PSEL, PENABLE, PWRITE, PADDR, PWDATA} = '0;
    repeat (20) @(posedge CLK);
    @(negedge CLK) RSTN = 1'b1;
    rd_chk("mode", OFF_MR, MR_RESET);
    rd_chk("pr0", OFF_PR0, REG_RESET);
    rd_chk("unmapped", 8'h50, 32'h0);
    rd_chk("misaligned", 8'h06, 32'h0);
    apb_wr(OFF_MR, 32'hFFFF_FFFF);
    rd_chk("mode", OFF_MR, MR_MASK);
    apb_wr(OFF_MR, 32'h0);
    i_nand_bus_model.page(CMD_PROG, 16'h0001, 512, 512, 0, 32'h0, 1'b0);
    rd_chk("pr1", OFF_PR1, 32'h0);
    rd_chk("pr0", OFF_PR0, 32'h1FF0_002A);
    i_nand_bus_model.pulse(3'h4, 16'h0030);
    i_nand_bus_model.pulse(3'h2, 16'h0000);
    rd_chk("pr0", OFF_PR0, 32'h1FF0_002A);
    i_nand_bus_model.pulse(3'h1, 16'h00FF);
    rd_chk("pr0", OFF_PR0, 32'h1FF0_002A);
    for (int k = 0; k < 4; k++) begin
      i_nand_bus_model.page(CMD_READ, w[k], 512, 512, 4, cd[k], 1'b0);
      rd_chk("sr1", OFF_SR1, sr[k]);
      if (k == 1) rd_chk("pr0", OFF_PR0, 32'h1);
      if (k == 3) rd_chk("pr0", OFF_PR0, 32'h1FF0_0025);
    end
    apb_wr(OFF_CR, 32'h1);
    rd_chk("sr1", OFF_SR1, 32'h0);
    apb_wr(OFF_MR, 32'h20);
    i_nand_bus_model.page(CMD_PROG, 16'h0001, 256, 512, 0, 32'h0, 1'b0);
    rd_chk("pr0", OFF_PR0, 32'h0FF0_002A);
    rd_chk("pr1", OFF_PR1, 32'h0FF0_002A);
    rd_chk("pr2", OFF_PR2, 32'h0);
    apb_wr(OFF_MR, 32'h11);
    i_nand_bus_model.page(CMD_PROG, 16'h0001, 512, 2048, 0, 32'h0, 1'b0);
    rd_chk("pr3", OFF_PR2 + 8'h04, 32'h1FF0_002A);
    rd_chk("pr4", OFF_PR2 + 8'h08, 32'h0);
    apb_wr(OFF_MR, 32'h02);
    i_nand_bus_model.page(CMD_PROG, 16'h0001, 4096, 4096, 0, 32'h0, 1'b0);
    rd_chk("pr0", OFF_PR0, 32'hFFF0_002A);
    rd_chk("pr1", OFF_PR1, 32'h0);
    apb_wr(OFF_MR, 32'h100);
    i_nand_bus_model.page(CMD_PROG, 16'h0001, 512, 512, 0, 32'h0, 1'b1);
    rd_chk("pr0", OFF_PR0, 32'h1FF0_00AA);
    apb_wr(OFF_CR, 32'h2);
    rd_chk("pr0", OFF_PR0, 32'h0);
    report_and_stop();
  end
endmodule : nand_page_ecc_engine_tb_top
